// ---- logic/can_status_pkg.sv ----
// Purpose: Constants for the bus status and error count report block
// Assumes: APB slave, 32-bit data, pclk at 10 MHz
// Notes:   Offsets are byte addresses
package can_status_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [11:0] STATUS_OFFSET = 12'h000;
  localparam logic [11:0] COUNTS_OFFSET = 12'h004;
  localparam logic [11:0] CLEAR_OFFSET  = 12'h008;
  localparam logic [11:0] MODE_OFFSET   = 12'h00C;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LEC_LSB       = 0;
  localparam int LEC_MSB       = 2;
  localparam int TX_OK_BIT     = 3;
  localparam int RX_OK_BIT     = 4;
  localparam int ERROR_PASSIVE_FLAG_BIT     = 5;
  localparam int WARN_BIT      = 6;
  localparam int BUS_OFF_FLAG_BIT      = 7;
  localparam int TEC_LSB       = 0;
  localparam int TEC_MSB       = 7;
  localparam int REC_LSB       = 8;
  localparam int REC_MSB       = 14;
  localparam int RP_BIT        = 15;
  localparam int CLR_TX_BIT    = 0;
  localparam int CLR_RX_BIT    = 1;
  localparam int CLR_LEC_BIT   = 2;

  // ************************************************************
  // Last error codes
  // ************************************************************
  localparam logic [2:0] LEC_NONE   = 3'h0;
  localparam logic [2:0] LEC_STUFF  = 3'h1;
  localparam logic [2:0] LEC_FORM   = 3'h2;
  localparam logic [2:0] LEC_ACK    = 3'h3;
  localparam logic [2:0] LEC_BIT1   = 3'h4;
  localparam logic [2:0] LEC_BIT0   = 3'h5;
  localparam logic [2:0] LEC_CRC    = 3'h6;
  localparam logic [2:0] LEC_UNUSED = 3'h7;

  // ************************************************************
  // Limits
  // ************************************************************
  localparam logic [7:0] WARN_LIMIT    = 8'h60;
  localparam logic [7:0] PASSIVE_LIMIT = 8'h80;
  localparam logic [7:0] BUSOFF_LIMIT  = 8'hFF;
  localparam logic [7:0] TEC_MAX       = 8'hFF;
  localparam logic [6:0] REC_MAX       = 7'h7F;
  localparam logic [7:0] TEC_TX_ERR    = 8'h08;
  localparam logic [6:0] REC_RX_ERR    = 7'h01;
  localparam logic [3:0] UPGRADE_POS   = 4'hF;
  localparam int         LED_COUNT     = 6;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ        = 10000000;
  localparam int SCROLL_MS     = 200;
  localparam int SCROLL_CYCLES = (CLK_HZ / 1000) * SCROLL_MS;

endpackage

// ---- logic/can_error_status_report.sv ----
// Purpose: Bus status flags, last error code and error counters over APB
// Assumes: Error and success events are one-cycle pulses from the protocol core
// Notes:   Also drives the upgrade-mode scrolling LED pattern
//
// Overview of operation
// RULE_01: Last error code sits in status bits 2:0; zero means no error.
// RULE_02: Stuff error pulse loads last error code 1.
// RULE_03: Form error pulse loads last error code 2.
// RULE_04: Unacknowledged transmitted frame loads last error code 3.
// RULE_05: Recessive sent but dominant seen, outside arbitration, loads code 4.
// RULE_06: Dominant sent but recessive seen loads code 5.
// RULE_07: Receive checksum mismatch loads code 6.
// RULE_08: Code 7 means no bus event detected.
// RULE_09: Status bit 3 set after a successful transmission.
// RULE_10: Status bit 4 set after any successful reception, filter aside.
// RULE_11: Status bit 5 shows error-passive state.
// RULE_12: Status bit 6 set while either counter has reached 96.
// RULE_13: Status bit 7 shows bus-off state.
// RULE_14: Transmit error counter in counter bits 7:0, maximum 255.
// RULE_15: Receive error counter in counter bits 14:8, maximum 127.
// RULE_16: Counter bit 15 set once receive counter reaches passive level.
// RULE_17: Operator sets first port switch to F before power-up for upgrade.
// RULE_18: In upgrade mode six LEDs scroll, one step every 200 ms.
// RULE_19: Last error code held until replaced; reserved bits read zero.
// RULE_20: Both error counters saturate and never wrap.
`timescale 1ns/10ps

module can_error_status_report #(
  parameter int SCROLL_CYCLES = can_status_pkg::SCROLL_CYCLES
) (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Protocol core events, one-cycle pulses
  input  wire logic        stuff_err,
  input  wire logic        form_err,
  input  wire logic        ack_err,
  input  wire logic        bit1_err,
  input  wire logic        bit0_err,
  input  wire logic        crc_err,
  input  wire logic        tx_done,
  input  wire logic        rx_done,
  input  wire logic        bus_event,
  // Switch and indicators
  input  wire logic [3:0]  first_bus_port_rate,
  output logic      [5:0]  led_q
);

  // ************************************************************
  // Switch synchroniser and strap capture
  // ************************************************************
  typedef enum logic [3:0] {
    STRAP_FILL1  = 4'b0001,
    STRAP_FILL2  = 4'b0010,
    STRAP_SAMPLE = 4'b0100,
    STRAP_DONE   = 4'b1000
  } strap_state_e;

  logic [3:0]   sw_meta_q;
  logic [3:0]   sw_sync_q;
  strap_state_e strap_state_q;
  logic         upgrade_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_q <= 4'h0;
      sw_sync_q <= 4'h0;
    end else begin
      sw_meta_q <= first_bus_port_rate;
      sw_sync_q <= sw_meta_q;
    end
  end

  // Two edges to fill the synchroniser, then a single look at the switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_state_q <= STRAP_FILL1;
    end else begin
      case (strap_state_q)
        STRAP_FILL1:  strap_state_q <= STRAP_FILL2;
        STRAP_FILL2:  strap_state_q <= STRAP_SAMPLE;
        STRAP_SAMPLE: strap_state_q <= STRAP_DONE;
        STRAP_DONE:   strap_state_q <= STRAP_DONE;
        default:      strap_state_q <= STRAP_FILL1;
      endcase
    end
  end

  // Mode fixed until the next reset; a later switch turn has no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upgrade_q <= 1'b0;
    end else if (strap_state_q == STRAP_SAMPLE) begin
      upgrade_q <= (sw_sync_q == can_status_pkg::UPGRADE_POS); // RULE_17
    end
  end

  // ************************************************************
  // Scrolling LED pattern
  // ************************************************************
  typedef enum logic [1:0] {
    SCROLL_IDLE = 2'b01,
    SCROLL_RUN  = 2'b10
  } scroll_state_e;

  scroll_state_e scroll_state_q;
  logic [31:0]   scroll_cnt_q;
  logic          scroll_step;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scroll_state_q <= SCROLL_IDLE;
    end else begin
      case (scroll_state_q)
        SCROLL_IDLE: begin
          if (upgrade_q) begin
            scroll_state_q <= SCROLL_RUN;
          end
        end
        SCROLL_RUN: begin
          if (!upgrade_q) begin
            scroll_state_q <= SCROLL_IDLE;
          end
        end
        default: begin
          scroll_state_q <= SCROLL_IDLE;
        end
      endcase
    end
  end

  // Step strobe once per scroll period while running
  assign scroll_step = (scroll_state_q == SCROLL_RUN) &&
                       (scroll_cnt_q == 32'(SCROLL_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scroll_cnt_q <= 32'h0;
    end else if ((scroll_state_q != SCROLL_RUN) || scroll_step) begin
      scroll_cnt_q <= 32'h0;
    end else begin
      scroll_cnt_q <= scroll_cnt_q + 32'h1;
    end
  end

  // First LED lit on entry, then one position left per step, wrapping round
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_q <= 6'h00;
    end else if (!upgrade_q) begin
      led_q <= 6'h00;
    end else if (scroll_state_q == SCROLL_IDLE) begin
      led_q <= 6'h01;
    end else if (scroll_step) begin
      led_q <= {led_q[can_status_pkg::LED_COUNT-2:0],
                led_q[can_status_pkg::LED_COUNT-1]}; // RULE_18
    end
  end

  // ************************************************************
  // APB decode
  // ************************************************************
  logic wr_en;
  logic hit;
  logic clr_tx;
  logic clr_rx;
  logic clr_lec;

  assign pready  = 1'b1;
  assign hit     = (paddr == can_status_pkg::STATUS_OFFSET) ||
                   (paddr == can_status_pkg::COUNTS_OFFSET) ||
                   (paddr == can_status_pkg::CLEAR_OFFSET)  ||
                   (paddr == can_status_pkg::MODE_OFFSET);
  assign pslverr = psel && penable && !hit;
  assign wr_en   = psel && penable && pwrite && (paddr == can_status_pkg::CLEAR_OFFSET);
  assign clr_tx  = wr_en && pwdata[can_status_pkg::CLR_TX_BIT];
  assign clr_rx  = wr_en && pwdata[can_status_pkg::CLR_RX_BIT];
  assign clr_lec = wr_en && pwdata[can_status_pkg::CLR_LEC_BIT];

  // ************************************************************
  // Last error code
  // ************************************************************
  logic [2:0] lec_q;
  logic       lec_load;
  logic [2:0] lec_code;

  // Highest-ranked error wins when several strike in one cycle
  always_comb begin
    lec_load = 1'b1;
    lec_code = can_status_pkg::LEC_NONE;
    if (stuff_err) begin
      lec_code = can_status_pkg::LEC_STUFF; // RULE_02
    end else if (form_err) begin
      lec_code = can_status_pkg::LEC_FORM; // RULE_03
    end else if (ack_err) begin
      lec_code = can_status_pkg::LEC_ACK; // RULE_04
    end else if (bit1_err) begin
      lec_code = can_status_pkg::LEC_BIT1; // RULE_05
    end else if (bit0_err) begin
      lec_code = can_status_pkg::LEC_BIT0; // RULE_06
    end else if (crc_err) begin
      lec_code = can_status_pkg::LEC_CRC; // RULE_07
    end else begin
      lec_load = 1'b0;
    end
  end

  // Code 7 until the first error, bus event or clear write, then held until replaced
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lec_q <= can_status_pkg::LEC_UNUSED; // RULE_08
    end else if (lec_load) begin
      lec_q <= lec_code; // RULE_19
    end else if (bus_event || clr_lec) begin
      lec_q <= can_status_pkg::LEC_NONE; // RULE_01
    end
  end

  // ************************************************************
  // Success flags, set wins over clear
  // ************************************************************
  logic tx_ok_q;
  logic rx_ok_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ok_q <= 1'b0;
    end else if (tx_done) begin
      tx_ok_q <= 1'b1; // RULE_09
    end else if (clr_tx) begin
      tx_ok_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ok_q <= 1'b0;
    end else if (rx_done) begin
      rx_ok_q <= 1'b1; // RULE_10
    end else if (clr_rx) begin
      rx_ok_q <= 1'b0;
    end
  end

  // ************************************************************
  // Error counters
  // ************************************************************
  logic [7:0] tec_q;
  logic [6:0] rec_q;
  logic       tx_err;
  logic       rx_err;
  logic       busoff;

  assign tx_err = ack_err || bit1_err || bit0_err;
  assign rx_err = stuff_err || form_err || crc_err;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tec_q <= 8'h00;
    end else if (tx_err) begin
      if (tec_q > can_status_pkg::TEC_MAX - can_status_pkg::TEC_TX_ERR) begin
        tec_q <= can_status_pkg::TEC_MAX; // RULE_20
      end else begin
        tec_q <= tec_q + can_status_pkg::TEC_TX_ERR;
      end
    end else if (tx_done && tec_q != 8'h00 && !busoff) begin
      tec_q <= tec_q - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_q <= 7'h00;
    end else if (rx_err) begin
      if (rec_q != can_status_pkg::REC_MAX) begin
        rec_q <= rec_q + can_status_pkg::REC_RX_ERR; // RULE_20
      end
    end else if (rx_done && rec_q != 7'h00) begin
      rec_q <= rec_q - 7'h01;
    end
  end

  typedef enum logic [1:0] {
    LINK_ON  = 2'b01,
    LINK_OFF = 2'b10
  } link_state_e;

  link_state_e link_state_q;

  // Bus-off entered at the counter ceiling and left only through reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_state_q <= LINK_ON;
    end else begin
      case (link_state_q)
        LINK_ON: begin
          if (tec_q == can_status_pkg::BUSOFF_LIMIT) begin
            link_state_q <= LINK_OFF; // RULE_13
          end
        end
        LINK_OFF: begin
          link_state_q <= LINK_OFF;
        end
        default: begin
          link_state_q <= LINK_ON;
        end
      endcase
    end
  end

  assign busoff = (link_state_q == LINK_OFF);

  // ************************************************************
  // Derived state flags
  // ************************************************************
  logic error_passive_flag;
  logic warn;
  logic rpass;

  assign rpass = ({1'b0, rec_q} >= can_status_pkg::PASSIVE_LIMIT - 8'h01); // RULE_16
  assign error_passive_flag = !busoff &&
                 ((tec_q >= can_status_pkg::PASSIVE_LIMIT) || rpass); // RULE_11
  assign warn  = (tec_q >= can_status_pkg::WARN_LIMIT) ||
                 ({1'b0, rec_q} >= can_status_pkg::WARN_LIMIT); // RULE_12

  // ************************************************************
  // Read data
  // ************************************************************
  logic [31:0] status_word;
  logic [31:0] counts_word;

  always_comb begin
    status_word = 32'h0; // RULE_19
    status_word[can_status_pkg::LEC_MSB:can_status_pkg::LEC_LSB] = lec_q; // RULE_01
    status_word[can_status_pkg::TX_OK_BIT] = tx_ok_q;
    status_word[can_status_pkg::RX_OK_BIT] = rx_ok_q;
    status_word[can_status_pkg::ERROR_PASSIVE_FLAG_BIT] = error_passive_flag;
    status_word[can_status_pkg::WARN_BIT]  = warn;
    status_word[can_status_pkg::BUS_OFF_FLAG_BIT]  = busoff;
    counts_word = 32'h0;
    counts_word[can_status_pkg::TEC_MSB:can_status_pkg::TEC_LSB] = tec_q; // RULE_14
    counts_word[can_status_pkg::REC_MSB:can_status_pkg::REC_LSB] = rec_q; // RULE_15
    counts_word[can_status_pkg::RP_BIT] = rpass;
  end

  logic        rd_setup;
  logic [31:0] rd_word;

  // Read data captured in the setup cycle, so the access phase needs no wait
  assign rd_setup = psel && !penable && !pwrite;

  always_comb begin
    case (paddr)
      can_status_pkg::STATUS_OFFSET: rd_word = status_word;
      can_status_pkg::COUNTS_OFFSET: rd_word = counts_word;
      can_status_pkg::MODE_OFFSET:   rd_word = {31'h0, upgrade_q};
      default:                       rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end

endmodule

// ---- dv/can_bus_node_model.sv ----
// Purpose: Far bus node model raising controller events
// Assumes: Bench holds one kind for one clock
// Notes:   1-6 errors, 7 clean event, 8 tx done, 9 rx done
`timescale 1ns/10ps
module can_bus_node_model (
  // Request
  input  wire logic [3:0] ev_kind,
  // Pulses
  output logic            stuff_err,
  output logic            form_err,
  output logic            ack_err,
  output logic            bit1_err,
  output logic            bit0_err,
  output logic            crc_err,
  output logic            bus_event,
  output logic            tx_done,
  output logic            rx_done
);
  assign stuff_err = ev_kind == 4'h1;
  assign form_err  = ev_kind == 4'h2;
  assign ack_err   = ev_kind == 4'h3;
  assign bit1_err  = ev_kind == 4'h4;
  assign bit0_err  = ev_kind == 4'h5;
  assign crc_err   = ev_kind == 4'h6;
  assign bus_event = ev_kind == 4'h7;
  assign tx_done   = ev_kind == 4'h8;
  assign rx_done   = ev_kind == 4'h9;
endmodule

// ---- dv/can_error_status_report_checker.sv ----
// Purpose: Port assertions for the status report block
// Assumes: Zero wait state reads
// Notes:   Bound below
`timescale 1ns/10ps
module can_error_status_report_checker #(
  parameter int SCROLL_CYCLES = can_status_pkg::SCROLL_CYCLES
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        stuff_err,
  input wire logic        form_err,
  input wire logic        ack_err,
  input wire logic [5:0]  led_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       rd_s, rd_c;
  logic [5:0] led_prev_q;
  int         gap_q;
  assign rd_s = psel && !penable && !pwrite && paddr == can_status_pkg::STATUS_OFFSET;
  assign rd_c = psel && !penable && !pwrite && paddr == can_status_pkg::COUNTS_OFFSET;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_prev_q <= 6'h00;
      gap_q      <= 0;
    end else begin
      led_prev_q <= led_q;
      gap_q      <= (led_q != led_prev_q) ? 0 : gap_q + 1;
    end
  end
  property p_stuff;
    rd_s && $past(stuff_err) |=> prdata[2:0] == 3'h1;
  endproperty
  a_stuff: assert property (p_stuff) else $error("stuff code wrong");
  property p_form;
    rd_s && $past(form_err && !stuff_err) |=> prdata[2:0] == 3'h2;
  endproperty
  a_form: assert property (p_form) else $error("form code wrong");
  property p_ack;
    rd_s && $past(ack_err && !stuff_err && !form_err) |=> prdata[2:0] == 3'h3;
  endproperty
  a_ack: assert property (p_ack) else $error("ack code wrong");
  property p_st_rsv;
    rd_s |=> prdata[31:8] == 24'h000000;
  endproperty
  a_st_rsv: assert property (p_st_rsv) else $error("status reserved set");
  property p_ct_rsv;
    rd_c |=> prdata[31:16] == 16'h0000;
  endproperty
  a_ct_rsv: assert property (p_ct_rsv) else $error("count reserved set");
  property p_led_one;
    led_q != 6'h00 |-> $onehot(led_q);
  endproperty
  a_led_one: assert property (p_led_one) else $error("led not one hot");
  property p_led_rot;
    led_prev_q != 6'h00 && led_q != led_prev_q |-> led_q == {led_prev_q[4:0], led_prev_q[5]};
  endproperty
  a_led_rot: assert property (p_led_rot) else $error("led step wrong");
  property p_led_gap;
    led_q != 6'h00 && led_prev_q != 6'h00 |-> gap_q <= SCROLL_CYCLES;
  endproperty
  a_led_gap: assert property (p_led_gap) else $error("led step late");
endmodule

bind can_error_status_report can_error_status_report_checker #(
  .SCROLL_CYCLES(SCROLL_CYCLES)
) i_can_error_status_report_checker (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .stuff_err, .form_err, .ack_err, .led_q);

// ---- dv/can_error_status_report_test.sv ----
// Purpose: Self-checking bench for the status report block
// Assumes: Short scroll period
// Notes:   Events come from the node model
`timescale 1ns/10ps
module can_error_status_report_test;
  localparam int SC = 10;
  localparam logic [11:0] ST = can_status_pkg::STATUS_OFFSET;
  localparam logic [11:0] CT = can_status_pkg::COUNTS_OFFSET;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic        stuff_err, form_err, ack_err, bit1_err, bit0_err, crc_err;
  logic        tx_done, rx_done, bus_event;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  ev_kind, rate;
  logic [5:0]  led_q;
  int          failures, check_count;
  can_error_status_report #(.SCROLL_CYCLES(SC)) i_can_error_status_report (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stuff_err,
    .form_err, .ack_err, .bit1_err, .bit0_err, .crc_err, .tx_done, .rx_done, .bus_event,
    .first_bus_port_rate(rate), .led_q);
  can_bus_node_model i_can_bus_node_model (.ev_kind, .stuff_err, .form_err, .ack_err,
    .bit1_err, .bit0_err, .crc_err, .bus_event, .tx_done, .rx_done);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic ev(input logic [3:0] k, input int n);
    repeat (n) begin
      ev_kind <= k;
      @(posedge pclk);
      ev_kind <= 4'h0;
      @(posedge pclk);
    end
  endtask
  task automatic do_reset;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_codes;
    rdc(ST, 32'h7);
    rdc(CT, 32'h0);
    rdc(can_status_pkg::MODE_OFFSET, 32'h0);
    for (int k = 1; k < 7; k++) begin
      // Read set up right after the pulse so the checker sees the pair
      ev_kind <= k[3:0];
      @(posedge pclk);
      ev_kind <= 4'h0;
      rdc(ST, k);
    end
    ev(4'h7, 1);
    rdc(ST, 32'h0);
    rdc(ST, 32'h0);
    rdc(CT, 32'h318);
  endtask
  task automatic t_ok;
    ev(4'h8, 1);
    ev(4'h9, 1);
    rdc(ST, 32'h18);
    rdc(CT, 32'h217);
    apb(1'b1, can_status_pkg::CLEAR_OFFSET, 32'h3);
    apb(1'b1, ST, 32'hFFFFFFFF);
    rdc(ST, 32'h0);
    rdc(12'h010, 32'h0);
    chk({31'h0, se}, 32'h1);
  endtask
  task automatic t_limits;
    ev(4'h6, 93);
    rdc(ST, 32'h06);
    ev(4'h6, 1);
    rdc(ST, 32'h46);
    ev(4'h6, 40);
    rdc(ST, 32'h66);
    rdc(CT, 32'hFF17);
    ev(4'h3, 30);
    rdc(ST, 32'hC3);
    rdc(CT, 32'hFFFF);
    apb(1'b1, can_status_pkg::CLEAR_OFFSET, 32'h4);
    rdc(ST, 32'hC0);
  endtask
  task automatic t_upgrade;
    logic [5:0] e;
    int n;
    rate <= 4'hF;
    do_reset();
    rdc(ST, 32'h7);
    rdc(CT, 32'h0);
    e = 6'h01;
    for (int i = 0; i < 7; i++) begin
      n = 0;
      while (led_q !== e && n < SC + 8) begin
        @(posedge pclk);
        n++;
      end
      chk({26'h0, led_q}, {26'h0, e});
      e = {e[4:0], e[5]};
    end
    rdc(can_status_pkg::MODE_OFFSET, 32'h1);
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #500000;
    failures++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, ev_kind, rate} = '0;
    failures = 0;
    check_count = 0;
    do_reset();
    t_codes();
    t_ok();
    t_limits();
    chk({26'h0, led_q}, 32'h0);
    t_upgrade();
    print_verdict();
  end
endmodule
